// [verilog/dld_map.vh]
// Purpose: register offsets, field positions and constants of the lock detector
// Assumes: apb byte addresses are four times the printed register index
// Notes: header only, no logic
`ifndef DLD_MAP_VH
`define DLD_MAP_VH
`define DLD_IDX_FTHR_P0 16'h0805
`define DLD_IDX_PROF_STRIDE 16'h0020
`define DLD_IDX_CLR_CH0 16'h200B
`define DLD_IDX_CLR_CH1 16'h2010
`define DLD_IDX_EVT_CH0 16'h3010
`define DLD_IDX_EVT_CH1 16'h3015
`define DLD_IDX_STAT_CH0 16'h3100
`define DLD_IDX_STAT_CH1 16'h3200
`define DLD_IDX_PTHR_P0 16'h0800
`define DLD_IDX_RATE_P0 16'h0804
`define DLD_IDX_CTRL_CH0 16'h2105
`define DLD_IDX_CTRL_CH1 16'h2205
`define DLD_BIT_PLOCK 1
`define DLD_BIT_FLOCK 2
`define DLD_BIT_EV_PLOCKED 0
`define DLD_BIT_EV_PUNLOCKED 1
`define DLD_BIT_EV_FLOCKED 2
`define DLD_BIT_EV_FUNLOCKED 3
`define DLD_LVL_EMPTY 13'h1800
`define DLD_LVL_FULL 13'h07FF
`define DLD_LVL_LOW_MARK 13'h1BFF
`define DLD_LVL_HIGH_MARK 13'h0400
`define DLD_THR_RESET 24'h000000
`define DLD_RATE_RESET 8'h00
`endif

// [verilog/dld_bucket.v]
// Purpose: one leaky-bucket lock detector
// Assumes: one sample strobe per decision, same clock
// Notes: level is signed 13 bit, -2048..+2047
`timescale 1ns/100ps
`include "dld_map.vh"
module dld_bucket (
  clk,
  rstn,
  sample_valid,
  err_mag,
  threshold,
  fill_rate,
  drain_rate,
  block_fill,
  force_unlock,
  locked_q
);
  input wire clk;
  input wire rstn;
  input wire sample_valid;
  input wire [23:0] err_mag;
  input wire [23:0] threshold;
  input wire [7:0] fill_rate;
  input wire [7:0] drain_rate;
  input wire block_fill;
  input wire force_unlock;
  output reg locked_q;

  reg signed [12:0] level_q;
  reg signed [13:0] sum;
  wire do_fill;

  // fill on small error, drain otherwise; never both
  assign do_fill = (err_mag <= threshold) && !block_fill;

  always @* begin
    if (do_fill) begin
      sum = {level_q[12], level_q} + {6'h00, fill_rate};
    end else begin
      sum = {level_q[12], level_q} - {6'h00, drain_rate};
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= `DLD_LVL_EMPTY;
      locked_q <= 1'b0;
    end else if (sample_valid) begin
      // saturate rather than wrap
      if (sum > $signed({1'b0, `DLD_LVL_FULL})) begin
        level_q <= `DLD_LVL_FULL;
      end else if (sum < $signed({1'b1, `DLD_LVL_EMPTY})) begin
        level_q <= `DLD_LVL_EMPTY;
      end else begin
        level_q <= sum[12:0];
      end
      if (force_unlock) begin
        locked_q <= 1'b0;
      end else if (sum > $signed({1'b0, `DLD_LVL_HIGH_MARK})) begin
        locked_q <= 1'b1;
      end else if (sum < $signed({1'b1, `DLD_LVL_LOW_MARK})) begin
        locked_q <= 1'b0;
      end
    end else if (force_unlock) begin
      locked_q <= 1'b0;
    end
  end
endmodule // dld_bucket

// [verilog/dld_top.v]
// Purpose: phase and frequency lock detectors for two loop channels, apb registers
// Assumes: samples from phase detector and period comparator arrive on clk
// Notes: zero-wait apb slave, pslverr on unmapped addresses
//
// Function
// - each channel has a phase lock detector; live status bit D1.
// - phase-locked event latches on unlocked to locked change.
// - phase-unlocked event latches on locked to unlocked change.
// - clear register bits 1:0 reset latched phase events.
// - accumulator spans -2048..+2047 and saturates at both ends.
// - lock above +1024, unlock below -1025, hold in between.
// - fill and drain amounts are 8-bit per-profile settings, eight profiles.
// - each sample fills if magnitude within threshold, else drains.
// - phase threshold is 24-bit picoseconds per profile.
// - active slew limiting blocks phase fill events.
// - freerun or holdover forces phase unlocked indication.
// - frequency detector uses same bucket on period deviation.
// - frequency detector ignores slew limiter.
// - live frequency lock status at bit D2.
// - frequency locked/unlocked events latch at bits 3:2.
// - clear register bits 3:2 reset latched frequency events.
// - frequency threshold is 24-bit picoseconds per profile.
// - frequency thresholds at 0x0805..0x08E5, 0x20 apart.
`timescale 1ns/100ps
`include "dld_map.vh"
module dld_top (
  clk,
  rstn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  ph_valid,
  ph_err,
  per_valid,
  per_dev,
  slew_active,
  freerun,
  holdover,
  phase_lock_q,
  freq_lock_q
);
  parameter NCH = 2;
  parameter NPROF = 8;
  input wire clk;
  input wire rstn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [17:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire [NCH-1:0] ph_valid;
  input wire [NCH*25-1:0] ph_err;
  input wire [NCH-1:0] per_valid;
  input wire [NCH*25-1:0] per_dev;
  input wire [NCH-1:0] slew_active;
  input wire [NCH-1:0] freerun;
  input wire [NCH-1:0] holdover;
  output reg [NCH-1:0] phase_lock_q;
  output reg [NCH-1:0] freq_lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage
  reg [23:0] pthr_q [0:NPROF-1];
  reg [23:0] fthr_q [0:NPROF-1];
  reg [7:0] pfill_q [0:NPROF-1];
  reg [7:0] pdrain_q [0:NPROF-1];
  reg [7:0] ffill_q [0:NPROF-1];
  reg [7:0] fdrain_q [0:NPROF-1];
  reg [2:0] prof_sel_q [0:NCH-1];
  reg [3:0] evt_q [0:NCH-1];
  reg [NCH-1:0] plock_d1_q;
  reg [NCH-1:0] flock_d1_q;
  wire [NCH-1:0] plock;
  wire [NCH-1:0] flock;

  wire [15:0] idx;
  wire wr_en;
  wire rd_en;
  assign idx = paddr[17:2];
  assign wr_en = psel && penable && pwrite;
  // read data is captured at the setup edge so that it stands through the access cycle
  assign rd_en = psel && !penable && !pwrite;

  // decode: which profile slot a given index hits at a given base
  function [3:0] prof_hit;
    input [15:0] a;
    input [15:0] base;
    reg [15:0] off;
    begin
      off = a - base;
      if (a >= base && off[4:0] == 5'h00 && off[15:5] < NPROF) begin
        prof_hit = {1'b1, off[7:5]};
      end else begin
        prof_hit = 4'h0;
      end
    end
  endfunction

  // magnitude of a signed 25 bit sample, sign is ignored
  function [23:0] mag;
    input [24:0] v;
    reg [24:0] n;
    begin
      n = v[24] ? (~v + 25'h0000001) : v;
      mag = n[24] ? 24'hFFFFFF : n[23:0];
    end
  endfunction

  wire [3:0] hit_p;
  wire [3:0] hit_f;
  wire [3:0] hit_r;
  assign hit_p = prof_hit(idx, `DLD_IDX_PTHR_P0);
  assign hit_f = prof_hit(idx, `DLD_IDX_FTHR_P0);
  assign hit_r = prof_hit(idx, `DLD_IDX_RATE_P0);

  ////////////////////////////////////////////////////////////////////////////
  // profile registers
  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < NPROF; i = i + 1) begin
        pthr_q[i] <= `DLD_THR_RESET;
        fthr_q[i] <= `DLD_THR_RESET;
        pfill_q[i] <= `DLD_RATE_RESET;
        pdrain_q[i] <= `DLD_RATE_RESET;
        ffill_q[i] <= `DLD_RATE_RESET;
        fdrain_q[i] <= `DLD_RATE_RESET;
      end
    end else if (wr_en) begin
      // no floor enforced: software keeps the phase threshold above 50 ps
      if (hit_p[3]) begin
        pthr_q[hit_p[2:0]] <= pwdata[23:0];
      end
      if (hit_f[3]) begin
        fthr_q[hit_f[2:0]] <= pwdata[23:0];
      end
      if (hit_r[3]) begin
        pfill_q[hit_r[2:0]] <= pwdata[7:0];
        pdrain_q[hit_r[2:0]] <= pwdata[15:8];
        ffill_q[hit_r[2:0]] <= pwdata[23:16];
        fdrain_q[hit_r[2:0]] <= pwdata[31:24];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel detectors and event latches
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      wire [15:0] clr_idx;
      wire [15:0] ctl_idx;
      wire [2:0] ps;
      wire clr_hit;
      assign clr_idx = (c == 0) ? `DLD_IDX_CLR_CH0 : `DLD_IDX_CLR_CH1;
      assign ctl_idx = (c == 0) ? `DLD_IDX_CTRL_CH0 : `DLD_IDX_CTRL_CH1;
      assign ps = prof_sel_q[c];
      assign clr_hit = wr_en && (idx == clr_idx);

      dld_bucket u_phase (
        .clk(clk),
        .rstn(rstn),
        .sample_valid(ph_valid[c]),
        .err_mag(mag(ph_err[c*25 +: 25])),
        .threshold(pthr_q[ps]),
        .fill_rate(pfill_q[ps]),
        .drain_rate(pdrain_q[ps]),
        .block_fill(slew_active[c]),
        .force_unlock(freerun[c] | holdover[c]),
        .locked_q(plock[c])
      );

      // same bucket, period deviation, slew limiter not connected
      dld_bucket u_freq (
        .clk(clk),
        .rstn(rstn),
        .sample_valid(per_valid[c]),
        .err_mag(mag(per_dev[c*25 +: 25])),
        .threshold(fthr_q[ps]),
        .fill_rate(ffill_q[ps]),
        .drain_rate(fdrain_q[ps]),
        .block_fill(1'b0),
        .force_unlock(1'b0),
        .locked_q(flock[c])
      );

      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          prof_sel_q[c] <= 3'h0;
        end else if (wr_en && idx == ctl_idx) begin
          prof_sel_q[c] <= pwdata[6:4];
        end
      end

      // set wins over a clear arriving in the same cycle
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          evt_q[c] <= 4'h0;
        end else begin
          evt_q[c] <= (evt_q[c] & ~(clr_hit ? pwdata[3:0] : 4'h0))
            | {~flock[c] & flock_d1_q[c], flock[c] & ~flock_d1_q[c],
               ~plock[c] & plock_d1_q[c],
               plock[c] & ~plock_d1_q[c]};
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      plock_d1_q <= {NCH{1'b0}};
      flock_d1_q <= {NCH{1'b0}};
      phase_lock_q <= {NCH{1'b0}};
      freq_lock_q <= {NCH{1'b0}};
    end else begin
      plock_d1_q <= plock;
      flock_d1_q <= flock;
      phase_lock_q <= plock;
      freq_lock_q <= flock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read and answer, zero wait states
  reg [31:0] rd_d;
  reg map_d;
  always @* begin
    rd_d = 32'h00000000;
    map_d = 1'b1;
    if (hit_p[3]) begin
      rd_d = {8'h00, pthr_q[hit_p[2:0]]};
    end else if (hit_f[3]) begin
      rd_d = {8'h00, fthr_q[hit_f[2:0]]};
    end else if (hit_r[3]) begin
      rd_d = {fdrain_q[hit_r[2:0]], ffill_q[hit_r[2:0]],
              pdrain_q[hit_r[2:0]], pfill_q[hit_r[2:0]]};
    end else begin
      case (idx)
        `DLD_IDX_EVT_CH0: rd_d = {28'h0000000, evt_q[0]};
        `DLD_IDX_EVT_CH1: rd_d = {28'h0000000, evt_q[1]};
        `DLD_IDX_STAT_CH0: rd_d = {29'h00000000, flock[0], plock[0], 1'b0};
        `DLD_IDX_STAT_CH1: rd_d = {29'h00000000, flock[1], plock[1], 1'b0};
        `DLD_IDX_CTRL_CH0: rd_d = {25'h0000000, prof_sel_q[0], 4'h0};
        `DLD_IDX_CTRL_CH1: rd_d = {25'h0000000, prof_sel_q[1], 4'h0};
        `DLD_IDX_CLR_CH0: rd_d = 32'h00000000;
        `DLD_IDX_CLR_CH1: rd_d = 32'h00000000;
        default: map_d = 1'b0;
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_d;
      prdata <= rd_en ? rd_d : 32'h00000000;
    end
  end
endmodule // dld_top

// [testbench/dld_top_checker.sv]
// Purpose: port checks of the lock detector
// Assumes: zero-wait apb; lock outputs follow a sample by two edges
// Notes: bound to dld_top
`timescale 1ns/100ps
module dld_top_checker #(parameter NCH = 2) (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [NCH-1:0] ph_valid,
  input wire [NCH-1:0] per_valid,
  input wire [NCH-1:0] slew_active,
  input wire [NCH-1:0] freerun,
  input wire [NCH-1:0] holdover,
  input wire [NCH-1:0] phase_lock_q,
  input wire [NCH-1:0] freq_lock_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // after a forced unlock the level may still sit above the mark, so a drain can relock
  logic forced_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      forced_q <= 1'b0;
    end else if (freerun[0] || holdover[0]) begin
      forced_q <= 1'b1;
    end
  end
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_plock_cause: assert property ($rose(phase_lock_q[0]) |-> $past(ph_valid[0], 2))
    else $error("lock without sample");
  a_slew_no_lock: assert property (
    $rose(phase_lock_q[0]) && !forced_q |-> !$past(slew_active[0], 2))
    else $error("lock while slewing");
  a_plock_drop: assert property (
    $fell(phase_lock_q[0]) |-> $past(ph_valid[0], 2) || $past(freerun[0], 2)
    || $past(holdover[0], 2)) else $error("unlock without cause");
  a_forced_zero: assert property (
    (freerun[0] || holdover[0]) |-> ##2 !phase_lock_q[0])
    else $error("lock while forced");
  a_forced_one: assert property (
    (freerun[1] || holdover[1]) |-> ##2 !phase_lock_q[1])
    else $error("lock while forced");
  a_flock_cause: assert property ($rose(freq_lock_q[0]) |-> $past(per_valid[0], 2))
    else $error("freq lock without sample");
  a_flock_drop: assert property ($fell(freq_lock_q[1]) |-> $past(per_valid[1], 2))
    else $error("freq unlock without sample");
endmodule // dld_top_checker
////////////////////
bind dld_top dld_top_checker #(.NCH(NCH)) i_chk (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .ph_valid(ph_valid), .per_valid(per_valid),
  .slew_active(slew_active), .freerun(freerun), .holdover(holdover),
  .phase_lock_q(phase_lock_q), .freq_lock_q(freq_lock_q));

// [testbench/dld_loop_model.sv]
// Purpose: far side: phase detector, period comparator, slew limiter
// Assumes: one sample per call, strobes one cycle long
// Notes: error lines scrambled outside the strobe, slew_active is held then
`timescale 1ns/100ps
module dld_loop_model (
  input wire clk,
  output reg [1:0] ph_valid = 2'h0,
  output reg [49:0] ph_err = 50'h0,
  output reg [1:0] per_valid = 2'h0,
  output reg [49:0] per_dev = 50'h0,
  output reg [1:0] slew_active = 2'h0
);
  task automatic sample(input int ch, input int pe, input int fd, input bit sl);
    @(posedge clk);
    ph_valid[ch] <= 1'b1;
    per_valid[ch] <= 1'b1;
    ph_err[ch*25+:25] <= pe[24:0];
    per_dev[ch*25+:25] <= fd[24:0];
    slew_active[ch] <= sl;
    @(posedge clk);
    ph_valid[ch] <= 1'b0;
    per_valid[ch] <= 1'b0;
    ph_err[ch*25+:25] <= ~pe[24:0];
    per_dev[ch*25+:25] <= ~fd[24:0];
  endtask
endmodule // dld_loop_model

// [testbench/testbench.sv]
// Purpose: self-checking bench of dld_top
// Assumes: profile 0 selected on both channels after reset
// Notes: a blocked fill counts as a drain, one action per sample
`timescale 1ns/100ps
`include "dld_map.vh"
module testbench;
  logic clk, rstn, psel, penable, pwrite, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, rd, w;
  logic [15:0] ix;
  logic [1:0] freerun, holdover, got;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [1:0] ph_valid, per_valid, slew_active, phase_lock_q, freq_lock_q;
  wire [49:0] ph_err, per_dev;
  int n_errors = 0;
  int checks_done = 0;
  int i, ch, p, m, pe, fd;
  int rt[4];
  int ev[2] = '{0, 0};
  int lk[2][2] = '{default: 0};
  int lvl[2][2] = '{default: -2048};
  dld_top i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ph_valid(ph_valid), .ph_err(ph_err), .per_valid(per_valid), .per_dev(per_dev),
    .slew_active(slew_active), .freerun(freerun), .holdover(holdover),
    .phase_lock_q(phase_lock_q), .freq_lock_q(freq_lock_q));
  dld_loop_model i_far (.clk(clk), .ph_valid(ph_valid), .ph_err(ph_err),
    .per_valid(per_valid), .per_dev(per_dev), .slew_active(slew_active));
  ////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {a, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge clk) n++; while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1, "apb answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic step(input int c, input int d, input int mag, input bit blk, input bit frc);
    int nl;
    if (mag > 100 || blk) lvl[c][d] -= rt[2 * d + 1];
    else lvl[c][d] += rt[2 * d];
    if (lvl[c][d] > 2047) lvl[c][d] = 2047;
    if (lvl[c][d] < -2048) lvl[c][d] = -2048;
    nl = frc ? 0 : (lvl[c][d] > 1024) ? 1 : (lvl[c][d] < -1025) ? 0 : lk[c][d];
    if (nl != lk[c][d]) ev[c] |= 1 << (2 * d + (nl ? 0 : 1));
    lk[c][d] = nl;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, rstn} = 4'h0;
    paddr = 18'h0;
    pwdata = 32'h0;
    {freerun, holdover} = 4'h0;
    void'($urandom(32'h69C7));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `DLD_IDX_STAT_CH0, 32'h0);
    chk(rd, 32'h0, "status after reset");
    apb(1'b0, `DLD_IDX_EVT_CH1, 32'h0);
    chk(rd, 32'h0, "events after reset");
    apb(1'b1, 16'h0001, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1, "unmapped write");
    apb(1'b1, `DLD_IDX_CTRL_CH1, 32'h70);
    apb(1'b0, `DLD_IDX_CTRL_CH1, 32'h0);
    chk(rd, 32'h70, "profile select readback");
    apb(1'b1, `DLD_IDX_CTRL_CH1, 32'h0);
    for (p = 0; p < 8; p++) begin
      ix = `DLD_IDX_FTHR_P0 + 16'(p) * `DLD_IDX_PROF_STRIDE;
      w = $urandom & 32'h00FFFFFF;
      apb(1'b1, ix, w);
      apb(1'b0, ix, 32'h0);
      chk(rd, w, "threshold readback");
    end
    $display("test registers done");
    foreach (rt[k]) rt[k] = $urandom_range(255, 160);
    apb(1'b1, `DLD_IDX_PTHR_P0, 32'h64);
    apb(1'b1, `DLD_IDX_FTHR_P0, 32'h64);
    apb(1'b1, `DLD_IDX_RATE_P0, {rt[3][7:0], rt[2][7:0], rt[1][7:0], rt[0][7:0]});
    for (ch = 0; ch < 2; ch++) begin
      for (i = 0; i < 60; i++) begin
        m = (i < 30) ? $urandom_range(100, 0) : $urandom_range(400, 101);
        pe = $urandom_range(1, 0) ? -m : m;
        fd = (i < 30) ? $urandom_range(100, 0) : -$urandom_range(400, 101);
        // channel one drains to a natural unlock before its holdover starts
        freerun[ch] <= (ch == 0 && i >= 30 && i < 45);
        holdover[ch] <= ch ? (i >= 55) : (i >= 45);
        i_far.sample(ch, pe, fd, i % 10 == 2);
        step(ch, 0, m, i % 10 == 2, ch ? i >= 55 : i >= 30);
        step(ch, 1, -fd > 0 ? -fd : fd, 1'b0, 1'b0);
        @(posedge clk);
        @(negedge clk);
        got = {phase_lock_q[ch], freq_lock_q[ch]};
        chk({30'h0, got}, 2 * lk[ch][0] + lk[ch][1], "lock outputs");
        @(posedge clk);
      end
      apb(1'b0, ch ? `DLD_IDX_STAT_CH1 : `DLD_IDX_STAT_CH0, 32'h0);
      chk(rd & 32'h6, 2 * lk[ch][0] + 4 * lk[ch][1], "live status");
      ix = ch ? `DLD_IDX_EVT_CH1 : `DLD_IDX_EVT_CH0;
      apb(1'b0, ix, 32'h0);
      chk(rd & 32'hF, ev[ch], "latched events");
      apb(1'b1, ch ? `DLD_IDX_CLR_CH1 : `DLD_IDX_CLR_CH0, 32'h3);
      apb(1'b0, ix, 32'h0);
      chk(rd & 32'hF, ev[ch] & 32'hC, "phase events after clear");
      apb(1'b1, ch ? `DLD_IDX_CLR_CH1 : `DLD_IDX_CLR_CH0, 32'hC);
      apb(1'b0, ix, 32'h0);
      chk(rd & 32'hF, 32'h0, "events after clear");
      freerun <= 2'h0;
      holdover <= 2'h0;
      $display("test channel %0d done", ch);
    end
    summarize();
  end
endmodule // testbench
